// >>> rtl/irs_ctrl.sv
`timescale 1ns/100ps
`include "irs_params.svh"
// Operation
// - Priority decision: three states external, two internal.
// - Exception waits for current instruction end.
// - Fetch cost: 1, 4, or 6+2m states.
// - Two fetches: prefetch and handler prefetch.
// - Two internal processing states, split in two.
// - Total response 11-31 normal, 12-32 advanced.
// - Enable clear acts after writing instruction.
// - Higher priority wins; cleared one dropped.
// - Flag clear behaves like enable clear.
// - After condition-code instruction, no interrupt accepted.
// - New mask effective two states later.
// - Byte block move is never interrupted.
// - Word block move breaks, stacks next address.
// - Source drives CPU, transfer engine, or both.
// - Transfer enable bit selects engine or CPU.
// - Select set: clear enable, forward to CPU.
// - Count zero: clear enable, forward to CPU.
// - Engine sources chosen by fixed order only.
// - Transfer runs first, then CPU exception.
// - Flag cleared by CPU or engine, but not once forwarded.
// - Serial and converter flags cleared by access.
// - Maskable held while mask set, except level 1 in mode 1 with user mask clear; NMI always.
// - Acceptance sets the interrupt mask bit.
module irs_ctrl #(
   parameter int           NSRC     = 8,
   parameter logic [7:0]   EXT_SRC  = 8'h0F,  // Sources on external pins.
   parameter logic [7:0]   ACC_CLR  = 8'hC0   // Serial/converter sources.
) (
   input  wire logic              mclk,
   input  wire logic              rstn,
   input  wire logic [NSRC-1:0]   src_flag,        // Source flags.
   input  wire logic [NSRC-1:0]   src_ien,         // Interrupt enables.
   input  wire logic [NSRC-1:0]   ctrl_level_reg,  // Control level per src.
   input  wire logic [NSRC-1:0]   transfer_enable_bit,
   input  wire logic [NSRC-1:0]   cpu_irq_select_bit,
   input  wire logic              nmi_req,
   input  wire logic              abrk_req,
   input  wire logic              intctl_mode1,    // Three-level masking.
   input  wire logic              adv_mode,        // Advanced address mode.
   input  wire logic              i_bit,           // Mask bit from CPU.
   input  wire logic              user_mask_bit,
   input  wire logic              instr_end,       // Instruction finished.
   input  wire logic              ccr_instr_end,   // It wrote cond_code_reg.
   input  wire logic              blk_byte_busy,   // Byte block move runs.
   input  wire logic              blk_word_busy,   // Word block move runs.
   input  wire logic              blk_word_break,  // Gap between transfers.
   input  wire irs_pkg::irs_space_t fetch_space,
   input  wire irs_pkg::irs_space_t stack_space,
   input  wire logic [1:0]        wait_cnt,        // Inserted waits m.
   input  wire logic              te_done,         // Transfer finished.
   input  wire logic [2:0]        te_done_src,
   input  wire logic              te_count_zero,
   output logic                   te_req,          // Engine activation.
   output logic [2:0]             te_src,
   output logic [NSRC-1:0]        te_en_clr,       // Clear enable pulse.
   output logic [NSRC-1:0]        flag_clr,        // Clear flag pulse.
   output logic                   accept,          // Exception started.
   output logic [7:0]             vec_code,
   output logic                   ret_next,        // Stack next address.
   output logic                   set_imask,       // Set mask bits.
   output logic                   handler_go,      // First handler fetch.
   output irs_pkg::irs_state_t    resp_state
);
   // Sequencer state and per-state countdown.
   irs_pkg::irs_state_t st_ff, nxt_st;
   logic [5:0]       cnt_ff, nxt_cnt;
   // Winner code and its stored flags.
   logic [7:0]       vec_ff, nxt_vec;
   logic             ret_ff, nxt_ret;
   // Requests seen during the current instruction; they survive a late
   // enable or flag clear until the instruction ends.
   logic [NSRC-1:0]  seen_ff, nxt_seen;
   // Requests forwarded to the CPU by the transfer engine.
   logic [NSRC-1:0]  fwd_ff, nxt_fwd;
   // Mask delay line, so a mask write acts two states late.
   logic [1:0]       imask_ff, nxt_imask;
   logic [1:0]       umask_ff, nxt_umask;
   // Registered pulse outputs.
   logic             acc_ff, nxt_acc, sim_ff, nxt_sim, hgo_ff, nxt_hgo;
   logic [NSRC-1:0]  fclr_ff, nxt_fclr, eclr_ff, nxt_eclr;
   logic             ter_ff, nxt_ter;
   logic [2:0]       tes_ff, nxt_tes;
   // Combinational helpers.
   logic [NSRC-1:0]  cpu_cand, masked_cand;
   logic             any_cand, acc_pt, blocked;
   logic [7:0]       win_code;
   logic [5:0]       s_fetch, s_stack, prio_len;

   // Access cost of one access in the given space.
   function automatic logic [5:0] irs_cost(irs_pkg::irs_space_t sp,
                                           logic [1:0] m);
      logic [5:0] c;
      c = `IRS_FETCH_INT_ST;
      if (sp == irs_pkg::IRS_SP_EXT2) begin
         c = `IRS_FETCH_EXT2_ST;
      end else if (sp == irs_pkg::IRS_SP_EXT3) begin
         c = `IRS_FETCH_EXT3_ST + {3'h0, m, 1'b0};
      end
      return c;
   endfunction

   // Candidates for the CPU: a source whose transfer enable is set does
   // not reach the CPU until the engine forwards it, so the data
   // transfer always precedes the exception.
   always_comb begin
      cpu_cand = ((src_flag & src_ien) | seen_ff)
                 & ~transfer_enable_bit;
      cpu_cand = cpu_cand | fwd_ff;
      // Level 0 waits for a clear mask; level 1 also passes in mode 1
      // with the user mask clear.
      for (int i = 0; i < NSRC; i++) begin
         masked_cand[i] = cpu_cand[i] & (~imask_ff[1] |
            (ctrl_level_reg[i] & intctl_mode1 & ~umask_ff[1]));
      end
      any_cand = nmi_req | abrk_req | (|masked_cand);
   end

   // Winner by fixed order: NMI, level 1 sources, address break, level 0.
   always_comb begin
      win_code = `IRS_VEC_ABRK;
      for (int i = NSRC - 1; i >= 0; i--) begin
         if (masked_cand[i] & ~ctrl_level_reg[i]) begin
            win_code = `IRS_VEC_SRC0 + 8'(i);
         end
      end
      if (!abrk_req) begin
         for (int i = NSRC - 1; i >= 0; i--) begin
            if (masked_cand[i] & ~ctrl_level_reg[i]) begin
               win_code = `IRS_VEC_SRC0 + 8'(i);
            end
         end
      end else begin
         win_code = `IRS_VEC_ABRK;
      end
      for (int i = NSRC - 1; i >= 0; i--) begin
         if (masked_cand[i] & ctrl_level_reg[i]) begin
            win_code = `IRS_VEC_SRC0 + 8'(i);
         end
      end
      if (nmi_req) begin
         win_code = `IRS_VEC_NMI;
      end
   end

   // Costs and acceptance point.  A byte move blocks everything and a
   // condition-code write lets the next instruction run first.
   always_comb begin
      s_fetch  = irs_cost(fetch_space, wait_cnt);
      s_stack  = irs_cost(stack_space, wait_cnt);
      prio_len = `IRS_PRIO_INT_ST;
      if (win_code == `IRS_VEC_NMI) begin
         prio_len = `IRS_PRIO_EXT_ST;
      end else if (win_code >= `IRS_VEC_SRC0 &&
                   EXT_SRC[3'(win_code - `IRS_VEC_SRC0)]) begin
         prio_len = `IRS_PRIO_EXT_ST;
      end
      blocked = ccr_instr_end | blk_byte_busy;
      acc_pt  = (instr_end & ~blk_word_busy) |
                (blk_word_busy & blk_word_break);
   end

   // Next-state logic of the response sequence and the engine side.
   always_comb begin
      nxt_st    = st_ff;
      nxt_cnt   = cnt_ff;
      nxt_vec   = vec_ff;
      nxt_ret   = ret_ff;
      nxt_acc   = 1'b0;
      nxt_sim   = 1'b0;
      nxt_hgo   = 1'b0;
      nxt_fclr  = '0;
      nxt_eclr  = '0;
      nxt_fwd   = fwd_ff;
      nxt_imask = {imask_ff[0], i_bit};
      nxt_umask = {umask_ff[0], user_mask_bit};
      // Requests seen mid-instruction stay until it ends.
      nxt_seen  = instr_end ? '0 : (seen_ff | (src_flag & src_ien));
      // Engine picks the lowest-numbered enabled source; masks and
      // levels play no part.
      nxt_ter   = 1'b0;
      nxt_tes   = tes_ff;
      for (int i = NSRC - 1; i >= 0; i--) begin
         if (src_flag[i] & transfer_enable_bit[i] & ~te_done) begin
            nxt_ter = 1'b1;
            nxt_tes = 3'(i);
         end
      end
      if (te_done) begin
         if (cpu_irq_select_bit[te_done_src] | te_count_zero) begin
            nxt_eclr[te_done_src] = 1'b1;
            nxt_fwd[te_done_src]  = 1'b1;
         end
         if (~cpu_irq_select_bit[te_done_src] & ~te_count_zero) begin
            nxt_fclr[te_done_src] = 1'b1;
         end
         if (ACC_CLR[te_done_src]) begin
            nxt_fclr[te_done_src] = 1'b1;
         end
      end
      unique case (st_ff)
         irs_pkg::IRS_IDLE: begin
            if (any_cand) begin
               nxt_st  = irs_pkg::IRS_PRIO;
               nxt_cnt = prio_len - 6'h01;
            end
         end
         irs_pkg::IRS_PRIO: begin
            if (cnt_ff == 6'h00) begin
               nxt_st = irs_pkg::IRS_WAITI;
            end else begin
               nxt_cnt = cnt_ff - 6'h01;
            end
         end
         irs_pkg::IRS_WAITI: begin
            if (acc_pt & ~blocked) begin
               // Winner is chosen at the end of the instruction; a lower request
               // whose flag or enable was cleared during it is dropped.
               if (any_cand) begin
                  nxt_vec = win_code;
                  nxt_ret = blk_word_busy;
                  nxt_acc = 1'b1;
                  nxt_st  = irs_pkg::IRS_PREF;
                  nxt_cnt = s_fetch - 6'h01;
                  if (win_code >= `IRS_VEC_SRC0) begin
                     if (fwd_ff[3'(win_code - `IRS_VEC_SRC0)]) begin
                        nxt_fwd[3'(win_code - `IRS_VEC_SRC0)] = 1'b0;
                     end else begin
                        nxt_fclr[3'(win_code - `IRS_VEC_SRC0)] = 1'b1;
                     end
                  end
               end else begin
                  nxt_st = irs_pkg::IRS_IDLE;
               end
            end
         end
         irs_pkg::IRS_PREF: begin
            if (cnt_ff == 6'h00) begin
               nxt_st  = irs_pkg::IRS_IPR1;
               nxt_cnt = `IRS_IPROC_ST - 6'h01;
            end else begin
               nxt_cnt = cnt_ff - 6'h01;
            end
         end
         irs_pkg::IRS_IPR1: begin
            nxt_st  = irs_pkg::IRS_STACK;
            nxt_cnt = 6'(`IRS_STACK_UNITS * s_stack) - 6'h01;
         end
         irs_pkg::IRS_STACK: begin
            if (cnt_ff == 6'h00) begin
               nxt_st  = irs_pkg::IRS_VEC;
               nxt_sim = 1'b1;
               nxt_cnt = (adv_mode ? {s_fetch[4:0], 1'b0} : s_fetch)
                         - 6'h01;
            end else begin
               nxt_cnt = cnt_ff - 6'h01;
            end
         end
         irs_pkg::IRS_VEC: begin
            if (cnt_ff == 6'h00) begin
               nxt_st = irs_pkg::IRS_IPR2;
            end else begin
               nxt_cnt = cnt_ff - 6'h01;
            end
         end
         irs_pkg::IRS_IPR2: begin
            nxt_st  = irs_pkg::IRS_HFET;
            nxt_cnt = s_fetch - 6'h01;
         end
         irs_pkg::IRS_HFET: begin
            if (cnt_ff == 6'h00) begin
               nxt_st  = irs_pkg::IRS_IDLE;
               nxt_hgo = 1'b1;
            end else begin
               nxt_cnt = cnt_ff - 6'h01;
            end
         end
         default: begin
            nxt_st = irs_pkg::IRS_IDLE;
         end
      endcase
   end

   // State registers; synchronous reset leaves masks set, as after
   // a chip reset, so nothing maskable is taken before software opens.
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         st_ff    <= irs_pkg::IRS_IDLE;
         cnt_ff   <= 6'h00;
         vec_ff   <= 8'h00;
         ret_ff   <= 1'b0;
         seen_ff  <= '0;
         fwd_ff   <= '0;
         imask_ff <= 2'h3;
         umask_ff <= 2'h3;
         acc_ff   <= 1'b0;
         sim_ff   <= 1'b0;
         hgo_ff   <= 1'b0;
         fclr_ff  <= '0;
         eclr_ff  <= '0;
         ter_ff   <= 1'b0;
         tes_ff   <= 3'h0;
      end else begin
         st_ff    <= nxt_st;
         cnt_ff   <= nxt_cnt;
         vec_ff   <= nxt_vec;
         ret_ff   <= nxt_ret;
         seen_ff  <= nxt_seen;
         fwd_ff   <= nxt_fwd;
         imask_ff <= nxt_imask;
         umask_ff <= nxt_umask;
         acc_ff   <= nxt_acc;
         sim_ff   <= nxt_sim;
         hgo_ff   <= nxt_hgo;
         fclr_ff  <= nxt_fclr;
         eclr_ff  <= nxt_eclr;
         ter_ff   <= nxt_ter;
         tes_ff   <= nxt_tes;
      end
   end

   assign te_req     = ter_ff;
   assign te_src     = tes_ff;
   assign te_en_clr  = eclr_ff;
   assign flag_clr   = fclr_ff;
   assign accept     = acc_ff;
   assign vec_code   = vec_ff;
   assign ret_next   = ret_ff;
   assign set_imask  = sim_ff;
   assign handler_go = hgo_ff;
   assign resp_state = st_ff;

   // Checks.
   chk_prio_ext: assert property (@(posedge mclk) disable iff (!rstn)
      st_ff == irs_pkg::IRS_IDLE && any_cand && prio_len == 6'h03
      |=> st_ff == irs_pkg::IRS_PRIO [*3] ##1 st_ff == irs_pkg::IRS_WAITI)
      else $error("priority phase length wrong");
   chk_no_acc_ccr: assert property (@(posedge mclk) disable iff (!rstn)
      ccr_instr_end |=> !accept) else $error("accept after ccr write");
   chk_no_acc_byte: assert property (@(posedge mclk) disable iff (!rstn)
      blk_byte_busy |=> !accept) else $error("accept in byte move");
   chk_word_ret: assert property (@(posedge mclk) disable iff (!rstn)
      accept && $past(blk_word_busy) |-> ret_next)
      else $error("word move return address wrong");
   chk_mask_dly: assert property (@(posedge mclk) disable iff (!rstn)
      $rose(i_bit) |-> !imask_ff[1] ##2 imask_ff[1])
      else $error("mask delay not two states");
   chk_imask_set: assert property (@(posedge mclk) disable iff (!rstn)
      accept |-> ##[4:40] set_imask) else $error("mask not set");
   chk_resp_int: assert property (@(posedge mclk) disable iff (!rstn)
      accept && fetch_space == irs_pkg::IRS_SP_INT &&
      stack_space == irs_pkg::IRS_SP_INT && !adv_mode
      |-> ##7 handler_go) else $error("response length wrong");
   chk_te_fwd: assert property (@(posedge mclk) disable iff (!rstn)
      te_done && te_count_zero |=> te_en_clr[$past(te_done_src)])
      else $error("enable not cleared at count zero");
   chk_acc_clr: assert property (@(posedge mclk) disable iff (!rstn)
      te_done && ACC_CLR[te_done_src] |=> flag_clr[$past(te_done_src)])
      else $error("serial flag not cleared");
endmodule

// >>> rtl/irs_params.svh
`ifndef IRS_PARAMS_SVH
`define IRS_PARAMS_SVH
// Priority determination length for external and on-chip sources.
`define IRS_PRIO_EXT_ST   6'h03
`define IRS_PRIO_INT_ST   6'h02
// Instruction-fetch cost per access class; three-state adds two per wait.
`define IRS_FETCH_INT_ST  6'h01
`define IRS_FETCH_EXT2_ST 6'h04
`define IRS_FETCH_EXT3_ST 6'h06
// Internal processing after acceptance and after the vector fetch.
`define IRS_IPROC_ST      6'h01
// Stack save takes two access units.
`define IRS_STACK_UNITS   2
// Mask writes by condition-code instructions act this many states late.
`define IRS_MASK_DLY      2
// Vector codes of the two unmaskable sources; sources start above them.
`define IRS_VEC_NMI       8'h00
`define IRS_VEC_ABRK      8'h01
`define IRS_VEC_SRC0      8'h02
`endif

// >>> rtl/irs_pkg.sv
package irs_pkg;
   // Sequencer states of the interrupt response.
   typedef enum logic [3:0] {
      IRS_IDLE  = 4'h0,
      IRS_PRIO  = 4'h1,
      IRS_WAITI = 4'h2,
      IRS_PREF  = 4'h3,
      IRS_IPR1  = 4'h4,
      IRS_STACK = 4'h5,
      IRS_VEC   = 4'h6,
      IRS_IPR2  = 4'h7,
      IRS_HFET  = 4'h8
   } irs_state_t;
   // Access class of a memory space.
   typedef enum logic [1:0] {
      IRS_SP_INT  = 2'h0,
      IRS_SP_EXT2 = 2'h1,
      IRS_SP_EXT3 = 2'h2
   } irs_space_t;
endpackage

// >>> tb/irs_far_model.sv
`timescale 1ns/100ps
// CPU instruction stream, peripheral flags and transfer engine.
module irs_far_model (
   input  wire logic       mclk,
   input  wire logic       rstn,
   input  wire logic [7:0] set_flag,      // Peripheral raises flags.
   input  wire logic [7:0] clr_flag,      // Handler clears flags.
   input  wire logic [7:0] flag_clr,      // Clear pulses from the block.
   input  wire logic       stall,         // A block move holds the end.
   input  wire logic       ccr_next,      // Each instruction writes masks.
   input  wire logic       slow,          // Engine answers late.
   input  wire logic       zero_cfg,      // Counter reaches zero.
   input  wire logic       te_req,
   input  wire logic [2:0] te_src,
   output logic [7:0]      src_flag,
   output logic            instr_end,
   output logic            ccr_instr_end,
   output logic            te_done,
   output logic [2:0]      te_done_src,
   output logic            te_count_zero
);
   logic [1:0] icnt;  // Every unstalled instruction lasts four states.
   logic [3:0] tcnt;  // Engine busy time plus a cool-down.
   // The cool-down keeps a request that is still high from firing twice.
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         src_flag <= 8'h00;
         icnt <= 2'h0;
         tcnt <= 4'h0;
         te_done <= 1'b0;
         te_done_src <= 3'h0;
      end else begin
         src_flag <= (src_flag | set_flag) & ~(clr_flag | flag_clr);
         icnt <= stall ? icnt : icnt + 2'h1;
         te_done <= (tcnt == 4'h5);
         if (tcnt != 4'h0) begin
            tcnt <= tcnt - 4'h1;
         end else if (te_req) begin
            tcnt <= slow ? 4'hD : 4'h7;
            te_done_src <= te_src;
         end
      end
   end
   assign instr_end = rstn && !stall && (icnt == 2'h3);
   assign ccr_instr_end = instr_end && ccr_next;
   assign te_count_zero = zero_cfg;
endmodule

// >>> tb/tb.sv
`timescale 1ns/100ps
module tb;
   logic mclk, rstn, nmi, abrk, adv, ibit, bbusy, wbusy, wbreak;
   logic ccr_next, slow, zero_cfg, instr_end, ccr_end, te_done, te_zero;
   logic [7:0] set_flag, clr_flag, src_ien, lvl, teb, sel, src_flag;
   logic [7:0] te_en_clr, flag_clr, vec_code;
   logic [2:0] te_src, te_done_src;
   logic te_req, accept, ret_next, set_imask, handler_go;
   irs_pkg::irs_space_t fspace;
   irs_pkg::irs_state_t resp_state;
   int n_mismatch, total_checks, n_acc, n_imask;
   irs_ctrl irs_ctrl_i (.mclk(mclk), .rstn(rstn), .src_flag(src_flag),
      .src_ien(src_ien), .ctrl_level_reg(lvl), .transfer_enable_bit(teb),
      .cpu_irq_select_bit(sel), .nmi_req(nmi), .abrk_req(abrk),
      .intctl_mode1(1'b0), .adv_mode(adv), .i_bit(ibit),
      .user_mask_bit(1'b0), .instr_end(instr_end), .ccr_instr_end(ccr_end),
      .blk_byte_busy(bbusy), .blk_word_busy(wbusy),
      .blk_word_break(wbreak), .fetch_space(fspace),
      .stack_space(irs_pkg::IRS_SP_INT), .wait_cnt(2'h0),
      .te_done(te_done), .te_done_src(te_done_src),
      .te_count_zero(te_zero), .te_req(te_req), .te_src(te_src),
      .te_en_clr(te_en_clr), .flag_clr(flag_clr), .accept(accept),
      .vec_code(vec_code), .ret_next(ret_next), .set_imask(set_imask),
      .handler_go(handler_go), .resp_state(resp_state));
   irs_far_model irs_far_model_i (.mclk(mclk), .rstn(rstn),
      .set_flag(set_flag), .clr_flag(clr_flag), .flag_clr(flag_clr),
      .stall(bbusy | wbusy), .ccr_next(ccr_next), .slow(slow),
      .zero_cfg(zero_cfg), .te_req(te_req), .te_src(te_src),
      .src_flag(src_flag), .instr_end(instr_end), .ccr_instr_end(ccr_end),
      .te_done(te_done), .te_done_src(te_done_src),
      .te_count_zero(te_zero));
   // Free-running 40 MHz clock.
   initial begin
      mclk = 1'b0;
      forever #12.5 mclk = ~mclk;
   end
   // Counts pulses so a scenario can tell whether one slipped by.
   always @(posedge mclk) begin
      if (accept === 1'b1) n_acc++;
      if (set_imask === 1'b1) n_imask++;
   end
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   // Inputs change and outputs are read 2 ns after the edge.
   task automatic tick(input int n);
      repeat (n) @(posedge mclk);
      #2;
   endtask
   function automatic logic pick(input int k);
      case (k)
         0: return accept;
         1: return handler_go;
         2: return te_req;
         default: return te_done;
      endcase
   endfunction
   // Bounded wait; a result equal to the limit means it never came.
   task automatic wait_on(input int k, input int lim, output int n);
      n = 0;
      while (pick(k) !== 1'b1 && n < lim) begin
         tick(1);
         n++;
      end
   endtask
   task automatic raise(input logic [7:0] m);
      set_flag = m;
      tick(1);
      set_flag = 8'h00;
   endtask
   // Handler end: flags cleared, masks restored as a return would.
   task automatic finish_handler;
      int n;
      wait_on(1, 60, n);
      clr_flag = 8'hFF;
      src_ien = 8'h00;
      nmi = 1'b0;
      abrk = 1'b0;
      tick(1);
      clr_flag = 8'h00;
      ibit = 1'b0;
      tick(6);
   endtask
   // Response from an external source over both modes and two fetch costs.
   task automatic sc_resp;
      int n, m, s, i0;
      for (int a = 0; a < 2; a++) begin
         for (int f = 0; f < 2; f++) begin
            adv = a[0];
            fspace = f ? irs_pkg::IRS_SP_EXT2 : irs_pkg::IRS_SP_INT;
            s = f ? 4 : 1;
            src_ien = 8'h02;
            raise(8'h02);
            wait_on(0, 60, n);
            i0 = n_imask;
            check(vec_code, 8'h03);
            check({7'h00, ret_next}, 8'h00);
            wait_on(1, 60, m);
            check(8'(resp_state), 8'h00);
            check(8'(m), 8'(3 * s + 4 + a * s));
            check(8'(n_imask - i0), 8'h01);
            if (f == 0) check(8'(n + m >= 11 + a && n + m <= 31 + a), 8'h01);
            finish_handler();
         end
      end
   endtask
   // Masked source waits; both unmaskable sources still get through.
   task automatic sc_mask;
      int n;
      ibit = 1'b1;
      src_ien = 8'h04;
      raise(8'h04);
      wait_on(0, 20, n);
      check(8'(n), 8'd20);
      for (int k = 0; k < 2; k++) begin
         nmi = (k == 0);
         abrk = (k == 1);
         wait_on(0, 20, n);
         check(vec_code, 8'(k));
         nmi = 1'b0;
         abrk = 1'b0;
         wait_on(1, 60, n);
         tick(2);
      end
      ibit = 1'b0;
      wait_on(0, 20, n);
      check(vec_code, 8'h04);
      finish_handler();
   endtask
   // Mask-writing instructions and byte moves both hold off an NMI.
   task automatic sc_hold(input int kind);
      int n;
      ccr_next = (kind == 0);
      bbusy = (kind == 1);
      nmi = 1'b1;
      wait_on(0, 20, n);
      check(8'(n), 8'd20);
      ccr_next = 1'b0;
      bbusy = 1'b0;
      wait_on(0, 20, n);
      check(vec_code, 8'h00);
      finish_handler();
   endtask
   // A word move is broken into at a gap and stacks the next address.
   task automatic sc_word;
      int n;
      src_ien = 8'h20;
      wbusy = 1'b1;
      raise(8'h20);
      wait_on(0, 8, n);
      check(8'(n), 8'd8);
      wbreak = 1'b1;
      tick(1);
      wbreak = 1'b0;
      wait_on(0, 20, n);
      check({7'h00, ret_next}, 8'h01);
      check(vec_code, 8'h07);
      wbusy = 1'b0;
      finish_handler();
   endtask
   // Engine outcomes: enable clear, flag clear and forwarding per case.
   task automatic sc_engine;
      int n, a0;
      logic [7:0] ec, fc;
      int src [4] = '{3, 3, 3, 6};
      logic [3:0] sl = 4'b1010, zr = 4'b0100, xe = 4'b1110, xf = 4'b1001;
      for (int c = 0; c < 4; c++) begin
         teb = 8'h01 << src[c];
         sel = 8'(sl[c]) << src[c];
         src_ien = teb;
         zero_cfg = zr[c];
         a0 = n_acc;
         raise(teb);
         wait_on(2, 10, n);
         check({5'h00, te_src}, 8'(src[c]));
         wait_on(3, 30, n);
         check(8'(n_acc - a0), 8'h00);
         ec = 8'h00;
         fc = 8'h00;
         repeat (3) begin
            ec |= te_en_clr;
            fc |= flag_clr;
            tick(1);
         end
         teb &= ~ec;
         check(ec, 8'(xe[c]) << src[c]);
         if (c != 2) check(fc, 8'(xf[c]) << src[c]);
         wait_on(0, 20, n);
         // The pulse counter sees an accept one edge after it appears.
         tick(1);
         check(8'(n_acc - a0), 8'(xe[c]));
         if (xe[c]) check(vec_code, 8'(2 + src[c]));
         if (xe[c]) finish_handler();
         teb = 8'h00;
         sel = 8'h00;
         src_ien = 8'h00;
         clr_flag = 8'hFF;
         tick(6);
         clr_flag = 8'h00;
      end
   endtask
   // Engine picks by fixed order, blind to the mask and the level.
   task automatic sc_order;
      int n;
      ibit = 1'b1;
      slow = 1'b1;
      lvl = 8'h10;
      teb = 8'h14;
      raise(8'h14);
      wait_on(2, 10, n);
      check({5'h00, te_src}, 8'h02);
      tick(40);
      teb = 8'h00;
      slow = 1'b0;
      lvl = 8'h00;
      ibit = 1'b0;
   endtask
   task automatic complete_run;
      if (n_mismatch == 0 && total_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   // The run needs about 600 states; this allows about ten times that.
   initial begin
      #150000;
      n_mismatch++;
      complete_run();
   end
   initial begin
      {rstn, nmi, abrk, adv, ibit, bbusy, wbusy, wbreak} = 8'h00;
      {ccr_next, slow, zero_cfg} = 3'h0;
      {set_flag, clr_flag, src_ien, lvl, teb, sel} = 48'h0;
      fspace = irs_pkg::IRS_SP_INT;
      tick(3);
      rstn = 1'b1;
      tick(2);
      sc_resp();
      sc_mask();
      sc_hold(0);
      sc_hold(1);
      sc_word();
      sc_engine();
      sc_order();
      complete_run();
   end
endmodule
